// ### design/abt_pkg.sv
/*
   Shared constants and types for the add and bit-test execution datapath.
   Assumes a 14-bit instruction word, an 8-bit accumulator and a 7-bit
   file-register address, all presented by the decoder in one cycle.
*/
package abt_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Widths.
   localparam int DATA_W  = 8;
   localparam int ADDR_W  = 7;
   localparam int BIT_W   = 3;
   localparam int INSTR_W = 14;

   ////////////////////////////////////////////////////////////////////////////
   // Instruction field positions.
   localparam int CLS_HI   = 13;
   localparam int CLS_LO   = 12;
   localparam int BOPC_HI  = 11;
   localparam int BOPC_LO  = 8;
   localparam int DEST_POS = 7;
   localparam int FADR_HI  = 6;
   localparam int FADR_LO  = 0;
   localparam int BITOP_HI = 11;
   localparam int BITOP_LO = 10;
   localparam int BITNO_HI = 9;
   localparam int BITNO_LO = 7;
   localparam int LADD_HI  = 11;
   localparam int LADD_LO  = 9;
   localparam int LIT_HI   = 7;
   localparam int LIT_LO   = 0;

   ////////////////////////////////////////////////////////////////////////////
   // Opcode encodings.
   localparam logic [1:0] CLS_BYTE      = 2'h0;
   localparam logic [1:0] CLS_BIT       = 2'h1;
   localparam logic [1:0] CLS_LIT       = 2'h3;
   localparam logic [3:0] OPC_FILE_ADD  = 4'h7;
   localparam logic [3:0] OPC_FILE_AND  = 4'h5;
   localparam logic [3:0] OPC_LIT_AND   = 4'h9;
   localparam logic [2:0] OPC_LIT_ADD   = 3'h7;
   localparam logic [1:0] BOP_ZERO      = 2'h0;
   localparam logic [1:0] BOP_ONE       = 2'h1;
   localparam logic [1:0] BOP_TEST_ZERO = 2'h2;
   localparam logic [1:0] BOP_TEST_ONE  = 2'h3;
   localparam logic       DEST_ACC      = 1'b0;
   localparam logic       DEST_FILE     = 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values and timing counts.
   localparam logic [7:0] ACC_RST       = 8'h00;
   localparam logic [1:0] SKIP_CYCLES   = 2'h2;
   localparam logic [1:0] NOP_CNT_LOAD  = SKIP_CYCLES - 2'h1;

   ////////////////////////////////////////////////////////////////////////////
   // Types.
   typedef enum logic [3:0] {
      OP_NONE      = 4'b0000,
      OP_LIT_ADD   = 4'b0001,
      OP_FILE_ADD  = 4'b0010,
      OP_LIT_AND   = 4'b0011,
      OP_FILE_AND  = 4'b0100,
      OP_BIT_ZERO  = 4'b0101,
      OP_BIT_ONE   = 4'b0110,
      OP_TEST_ZERO = 4'b0111,
      OP_TEST_ONE  = 4'b1000
   } abt_op_t;

   typedef enum logic [0:0] {
      ST_EXEC = 1'b0,
      ST_NOP  = 1'b1
   } abt_state_t;

   typedef struct packed {
      logic carry;
      logic half_byte_overflow_flag;
      logic zero;
   } abt_flags_t;

   typedef struct packed {
      logic              en;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } abt_wr_t;

   localparam abt_flags_t FLAGS_RST = '{carry: 1'b0, half_byte_overflow_flag: 1'b0, zero: 1'b0};
   localparam abt_wr_t    WR_RST    = '{en: 1'b0, addr: 7'h00, data: 8'h00};

endpackage : abt_pkg

// ### design/abt_add8.sv
/*
   Eight-bit adder with carry out of bit 7 and carry out of bit 3.
   Purely combinational; the caller registers the results.
*/
module abt_add8 (
   input  wire logic [7:0] a,
   input  wire logic [7:0] b,
   output logic      [7:0] sum,
   output logic            carry,
   output logic            half_carry
);

   logic [4:0] lo_sum;
   logic [4:0] hi_sum;

   ////////////////////////////////////////////////////////////////////////////
   // Low and high nibbles are added apart so the bit 3 carry is visible.
   always_comb begin
      lo_sum     = {1'b0, a[3:0]} + {1'b0, b[3:0]};
      hi_sum     = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo_sum[4]};
      sum        = {hi_sum[3:0], lo_sum[3:0]};
      carry      = hi_sum[4];  // Carry out of bit 7. [RQ13]
      half_carry = lo_sum[4];  // Carry out of bit 3. [RQ13]
   end

endmodule : abt_add8

// ### design/abt_exec.sv
/*
   Execution datapath for literal and file add, literal and file AND,
   bit clear, bit set and the two bit-test-and-skip operations.
   Assumes the decoder presents one instruction per instruction cycle with
   instr_valid, and that the file-register space outside presents the
   addressed register's latch contents and, for port registers, the pin
   levels in the same cycle. The sequencer uses its no-operation state to
   replace the instruction slot after a taken skip with a no-operation,
   and discard_r marks that slot.
*/
// Behaviour
// RQ1: Literal add: accumulator plus literal into accumulator.
// RQ2: File add: accumulator plus file register, flags updated.
// RQ3: Destination bit 0 accumulator, 1 file register.
// RQ4: Literal AND into accumulator, zero flag only.
// RQ5: File AND to destination, zero flag only.
// RQ6: Bit clear forces chosen bit zero, flags untouched.
// RQ7: Bit set forces chosen bit one, flags untouched.
// RQ8: Test-one-skip skips next instruction when bit one.
// RQ9: Test-zero-skip skips next instruction when bit zero.
// RQ10: Seven-bit file address, three-bit bit position.
// RQ11: Taken skip spends a second no-operation cycle.
// RQ12: Port read-modify-write uses pin levels, not latch.
// RQ13: Carry from bit 7, half from bit 3, zero.
// RQ14: Untaken bit test completes in one cycle.
module abt_exec (
   input  wire logic                       mclk,
   input  wire logic                       rstn,
   input  wire logic                       instr_valid,
   input  wire logic [abt_pkg::INSTR_W-1:0] instr,
   input  wire logic [abt_pkg::DATA_W-1:0]  file_latch_data,
   input  wire logic [abt_pkg::DATA_W-1:0]  file_pin_data,
   input  wire logic                       file_is_port,
   output abt_pkg::abt_flags_t             flags_r,
   output abt_pkg::abt_wr_t                file_wr_r,
   output logic [abt_pkg::DATA_W-1:0]      acc_r,
   output logic                            discard_r,
   output logic                            done_r,
   output logic                            ignored_r
);


   // Sequencer state and skip bookkeeping.
   abt_pkg::abt_state_t                state_r;
   abt_pkg::abt_state_t                state_nxt;
   logic [1:0]                         nop_cnt_r;

   // Decoded operation and fields.
   abt_pkg::abt_op_t                   op;
   logic [1:0]                         cls;
   logic [abt_pkg::ADDR_W-1:0]         faddr;
   logic [abt_pkg::BIT_W-1:0]          bitno;
   logic                               dest;
   logic [abt_pkg::DATA_W-1:0]         literal;
   logic [abt_pkg::DATA_W-1:0]         operand;

   // Adder operand and results.
   logic [abt_pkg::DATA_W-1:0]         add_b;
   logic [abt_pkg::DATA_W-1:0]         add_sum;
   logic                               add_carry;
   logic                               add_half;

   // Result and write-back controls.
   logic [abt_pkg::DATA_W-1:0]         bit_mask;
   logic [abt_pkg::DATA_W-1:0]         result;
   logic                               tested_bit;
   logic                               skip_taken;
   logic                               take;
   logic                               to_acc;
   logic                               to_file;
   logic                               arith;
   logic                               logic_op;

   ////////////////////////////////////////////////////////////////////////////
   // Field extraction.
   // Address and bit number are fixed-width slices of the word.
   assign cls     = instr[abt_pkg::CLS_HI:abt_pkg::CLS_LO];
   assign faddr   = instr[abt_pkg::FADR_HI:abt_pkg::FADR_LO];      // [RQ10]
   assign bitno   = instr[abt_pkg::BITNO_HI:abt_pkg::BITNO_LO];    // [RQ10]
   assign dest    = instr[abt_pkg::DEST_POS];
   assign literal = instr[abt_pkg::LIT_HI:abt_pkg::LIT_LO];

   ////////////////////////////////////////////////////////////////////////////
   // Operation decode.
   // Anything outside the eight handled operations decodes to OP_NONE.
   // Both literal forms share one class.
   always_comb begin
      op = abt_pkg::OP_NONE;
      case (cls)
         abt_pkg::CLS_BYTE: begin
            if (instr[abt_pkg::BOPC_HI:abt_pkg::BOPC_LO] == abt_pkg::OPC_FILE_ADD) begin
               op = abt_pkg::OP_FILE_ADD;
            end else if (instr[abt_pkg::BOPC_HI:abt_pkg::BOPC_LO] == abt_pkg::OPC_FILE_AND) begin
               op = abt_pkg::OP_FILE_AND;
            end
         end
         abt_pkg::CLS_BIT: begin
            case (instr[abt_pkg::BITOP_HI:abt_pkg::BITOP_LO])
               abt_pkg::BOP_ZERO:      op = abt_pkg::OP_BIT_ZERO;
               abt_pkg::BOP_ONE:       op = abt_pkg::OP_BIT_ONE;
               abt_pkg::BOP_TEST_ZERO: op = abt_pkg::OP_TEST_ZERO;
               default:                op = abt_pkg::OP_TEST_ONE;
            endcase
         end
         abt_pkg::CLS_LIT: begin
            if (instr[abt_pkg::LADD_HI:abt_pkg::LADD_LO] == abt_pkg::OPC_LIT_ADD) begin
               op = abt_pkg::OP_LIT_ADD;
            end else if (instr[abt_pkg::BOPC_HI:abt_pkg::BOPC_LO] == abt_pkg::OPC_LIT_AND) begin
               op = abt_pkg::OP_LIT_AND;
            end
         end
         default: begin
            op = abt_pkg::OP_NONE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // File operand selection.
   // A port register feeds back its pin levels so that a pin held low
   // outside is written back as zero, not as the latched one.
   assign operand = file_is_port ? file_pin_data : file_latch_data;  // [RQ12]

   ////////////////////////////////////////////////////////////////////////////
   // Shared adder for both add forms.
   // Literal add feeds the immediate.
   assign add_b = (op == abt_pkg::OP_LIT_ADD) ? literal : operand;

   abt_add8 u_add (
      .a          (acc_r),
      .b          (add_b),
      .sum        (add_sum),
      .carry      (add_carry),
      .half_carry (add_half)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Result, destination and skip evaluation.
   // An instruction is taken only in the execute state; the slot after a
   // taken skip is swallowed whatever it holds.
   // Bit tests read the bit writes' operand.
   always_comb begin
      take       = instr_valid && (state_r == abt_pkg::ST_EXEC);
      bit_mask   = 8'h01 << bitno;
      tested_bit = operand[bitno];
      result     = acc_r;
      to_acc     = 1'b0;
      to_file    = 1'b0;
      arith      = 1'b0;
      logic_op   = 1'b0;
      skip_taken = 1'b0;
      case (op)
         abt_pkg::OP_LIT_ADD: begin
            result = add_sum;                                   // [RQ1]
            to_acc = 1'b1;                                      // [RQ1]
            arith  = 1'b1;
         end
         abt_pkg::OP_FILE_ADD: begin
            result  = add_sum;                                  // [RQ2]
            to_acc  = (dest == abt_pkg::DEST_ACC);              // [RQ3]
            to_file = (dest == abt_pkg::DEST_FILE);             // [RQ3]
            arith   = 1'b1;
         end
         abt_pkg::OP_LIT_AND: begin
            result   = acc_r & literal;                         // [RQ4]
            to_acc   = 1'b1;
            logic_op = 1'b1;
         end
         abt_pkg::OP_FILE_AND: begin
            result   = acc_r & operand;                         // [RQ5]
            to_acc   = (dest == abt_pkg::DEST_ACC);             // [RQ3]
            to_file  = (dest == abt_pkg::DEST_FILE);            // [RQ3]
            logic_op = 1'b1;
         end
         abt_pkg::OP_BIT_ZERO: begin
            result  = operand & ~bit_mask;                      // [RQ6]
            to_file = 1'b1;
         end
         abt_pkg::OP_BIT_ONE: begin
            result  = operand | bit_mask;                       // [RQ7]
            to_file = 1'b1;
         end
         abt_pkg::OP_TEST_ONE: begin
            skip_taken = tested_bit;                            // [RQ8]
         end
         abt_pkg::OP_TEST_ZERO: begin
            skip_taken = ~tested_bit;                           // [RQ9]
         end
         default: begin
            result = acc_r;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Skip sequencing state.
   // A taken skip moves to the no-operation state; an untaken test stays
   // in execute, so the next instruction runs in the following cycle.
   // The no-operation state lasts one slot.
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         abt_pkg::ST_EXEC: begin
            if (take && skip_taken) begin
               state_nxt = abt_pkg::ST_NOP;                     // [RQ11]
            end else begin
               state_nxt = abt_pkg::ST_EXEC;                    // [RQ14]
            end
         end
         abt_pkg::ST_NOP: begin
            if (nop_cnt_r <= 2'h1) begin
               state_nxt = abt_pkg::ST_EXEC;
            end
         end
         default: begin
            state_nxt = abt_pkg::ST_EXEC;
         end
      endcase
   end

   // State register.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state_r <= abt_pkg::ST_EXEC;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Counts the no-operation cycles left so a taken skip lasts two cycles.
   // Only a taken skip reloads it.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         nop_cnt_r <= 2'h0;
      end else if (take && skip_taken) begin
         nop_cnt_r <= abt_pkg::NOP_CNT_LOAD;                    // [RQ8] [RQ9]
      end else if (nop_cnt_r != 2'h0) begin
         nop_cnt_r <= nop_cnt_r - 2'h1;
      end
   end

   // Marks the swallowed slot; high for exactly the cycle after a taken skip.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         discard_r <= 1'b0;
      end else begin
         discard_r <= take && skip_taken;                       // [RQ11]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Accumulator.
   // Written only by a taken instruction.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         acc_r <= abt_pkg::ACC_RST;
      end else if (take && to_acc) begin
         acc_r <= result;                                       // [RQ1] [RQ3] [RQ4]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status flags.
   // Adds write all three flags, ANDs only zero, bit operations none.
   // Skips and bit writes leave them alone.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         flags_r <= abt_pkg::FLAGS_RST;
      end else if (take && arith) begin
         flags_r.carry                   <= add_carry;          // [RQ13]
         flags_r.half_byte_overflow_flag <= add_half;           // [RQ13]
         flags_r.zero                    <= (result == 8'h00);  // [RQ13]
      end else if (take && logic_op) begin
         flags_r.zero <= (result == 8'h00);                     // [RQ4] [RQ5]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // File write port.
   // One-cycle write strobe with the address and data held alongside.
   // Address and data hold between writes.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         file_wr_r <= abt_pkg::WR_RST;
      end else begin
         file_wr_r.en <= take && to_file;                       // [RQ3] [RQ6] [RQ7]
         if (take && to_file) begin
            file_wr_r.addr <= faddr;
            file_wr_r.data <= result;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Completion and ignore pulses.
   // done marks a handled instruction; ignored marks one outside this set.
   // A discarded slot raises neither.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         done_r    <= 1'b0;
         ignored_r <= 1'b0;
      end else begin
         done_r    <= take && (op != abt_pkg::OP_NONE);
         ignored_r <= take && (op == abt_pkg::OP_NONE);
      end
   end

endmodule : abt_exec

// ### tb/abt_exec_chk.sv
/*
   Port-level checker for the add and bit-test datapath.
   Assumes one instruction is taken per rising mclk edge, outside a discard slot.
*/
module abt_exec_chk (
   input wire logic                  mclk,
   input wire logic                  rstn,
   input wire logic                  instr_valid,
   input wire logic [13:0]           instr,
   input wire logic [7:0]            file_latch_data,
   input wire logic [7:0]            file_pin_data,
   input wire logic                  file_is_port,
   input wire abt_pkg::abt_flags_t   flags_r,
   input wire abt_pkg::abt_wr_t      file_wr_r,
   input wire logic [7:0]            acc_r,
   input wire logic                  discard_r,
   input wire logic                  done_r,
   input wire logic                  ignored_r
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] opnd, opb, sres, aand, mask, bexp;
   logic [8:0] s9;
   logic [4:0] h5;
   logic       tk, sc, sh, skipc, lit, is_ladd, is_land, is_fadd, is_fand, is_bwr, is_tst;

   // Expected results worked out from the operands presented this cycle.
   always_comb begin
      opnd    = file_is_port ? file_pin_data : file_latch_data;
      lit     = instr[13:12] == abt_pkg::CLS_LIT;
      opb     = lit ? instr[7:0] : opnd;
      s9      = {1'b0, acc_r} + {1'b0, opb};
      h5      = {1'b0, acc_r[3:0]} + {1'b0, opb[3:0]};
      sres    = s9[7:0];
      sc      = s9[8];
      sh      = h5[4];
      aand    = acc_r & opb;
      mask    = 8'h01 << instr[9:7];
      bexp    = (instr[11:10] == abt_pkg::BOP_ONE) ? (opnd | mask) : (opnd & ~mask);
      skipc   = (instr[11:10] == abt_pkg::BOP_TEST_ONE) == (|(opnd & mask));
      tk      = instr_valid && !discard_r;
      is_ladd = tk && lit && instr[11:9] == abt_pkg::OPC_LIT_ADD;
      is_land = tk && lit && instr[11:8] == abt_pkg::OPC_LIT_AND;
      is_fadd = tk && instr[13:12] == abt_pkg::CLS_BYTE && instr[11:8] == abt_pkg::OPC_FILE_ADD;
      is_fand = tk && instr[13:12] == abt_pkg::CLS_BYTE && instr[11:8] == abt_pkg::OPC_FILE_AND;
      is_bwr  = tk && instr[13:12] == abt_pkg::CLS_BIT && !instr[11];
      is_tst  = tk && instr[13:12] == abt_pkg::CLS_BIT && instr[11];
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);

   ////////////////////////////////////////////////////////////////////////////
   lit_add_a: assert property (is_ladd |=> acc_r == $past(sres) && flags_r.carry == $past(sc) &&
      flags_r.half_byte_overflow_flag == $past(sh) && flags_r.zero == (acc_r == 8'h00))
      else $error("literal add result or flags wrong");
   fadd_file_a: assert property (is_fadd && instr[7] |=> file_wr_r.en && file_wr_r.data == $past(sres) &&
      file_wr_r.addr == $past(instr[6:0]) && $stable(acc_r) && flags_r.carry == $past(sc))
      else $error("file add to register wrong");
   fadd_acc_a: assert property (is_fadd && !instr[7] |=> !file_wr_r.en && acc_r == $past(sres) &&
      flags_r.half_byte_overflow_flag == $past(sh)) else $error("file add to accumulator wrong");
   lit_and_a: assert property (is_land |=> acc_r == $past(aand) && $stable(flags_r.carry) &&
      $stable(flags_r.half_byte_overflow_flag) && flags_r.zero == (acc_r == 8'h00)) else $error("literal and wrong");
   file_and_a: assert property (is_fand |=> file_wr_r.en == $past(instr[7]) && $stable(flags_r.carry) &&
      (file_wr_r.en ? file_wr_r.data : acc_r) == $past(aand) && flags_r.zero == ($past(aand) == 8'h00))
      else $error("file and wrong");
   bit_write_a: assert property (is_bwr |=> file_wr_r.en && file_wr_r.data == $past(bexp) &&
      file_wr_r.addr == $past(instr[6:0]) && $stable(flags_r)) else $error("bit clear or set wrong");
   skip_taken_a: assert property (is_tst && skipc |=> discard_r && done_r ##1 !discard_r)
      else $error("taken skip not two cycles");
   skip_not_a: assert property (is_tst && !skipc |=> done_r && !discard_r && !file_wr_r.en && $stable(acc_r))
      else $error("untaken test wrong");
   slot_drop_a: assert property (discard_r |=> !done_r && !ignored_r && !file_wr_r.en && $stable(acc_r))
      else $error("discarded slot had effect");

   // Main scenarios reached.
   skip_c: cover property (is_tst && skipc);
   fadd_c: cover property (is_fadd && instr[7]);
   port_c: cover property (is_bwr && file_is_port);
endmodule : abt_exec_chk

bind abt_exec abt_exec_chk u_chk (.mclk(mclk), .rstn(rstn), .instr_valid(instr_valid), .instr(instr),
   .file_latch_data(file_latch_data), .file_pin_data(file_pin_data), .file_is_port(file_is_port),
   .flags_r(flags_r), .file_wr_r(file_wr_r), .acc_r(acc_r), .discard_r(discard_r), .done_r(done_r),
   .ignored_r(ignored_r));

// ### tb/abt_exec_tb.sv
/*
   Self-checking bench for abt_exec with a small accumulator and flag model.
   Assumes the checker is bound to the design by its own file.
*/
module abt_exec_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic                mclk, rstn, instr_valid, file_is_port;
   logic [13:0]         instr;
   logic [7:0]          file_latch_data, file_pin_data, acc_r, acc_m;
   logic [2:0]          fl_m;
   abt_pkg::abt_flags_t flags_r;
   abt_pkg::abt_wr_t    file_wr_r;
   logic                discard_r, done_r, ignored_r;
   int                  n_mismatch = 0;
   int                  cmp_count = 0;
   int                  cyc = 0;

   abt_exec u_abt_exec (.mclk(mclk), .rstn(rstn), .instr_valid(instr_valid), .instr(instr),
      .file_latch_data(file_latch_data), .file_pin_data(file_pin_data), .file_is_port(file_is_port),
      .flags_r(flags_r), .file_wr_r(file_wr_r), .acc_r(acc_r), .discard_r(discard_r), .done_r(done_r),
      .ignored_r(ignored_r));

   // Clock at 4 ns period.
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   // Cuts a hang short well beyond the fewer than one hundred cycles the tests need.
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_mismatch++;
         $display("[FAIL] t=%0t timeout", $time);
         tally_and_finish();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk_b(input logic [7:0] got, input logic [7:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk_b

   task automatic chk_s(input logic [2:0] got, input logic [2:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t %s got %b exp %b", $time, what, got, exp);
      end
   endtask : chk_s

   // Presents one instruction for one edge, then lowers valid on the taking edge.
   task automatic run_op(input logic [13:0] i, input logic [7:0] lat, input logic [7:0] pin, input logic port);
      @(posedge mclk);
      instr_valid     <= 1'b1;
      instr           <= i;
      file_latch_data <= lat;
      file_pin_data   <= pin;
      file_is_port    <= port;
      @(posedge mclk);
      instr_valid <= 1'b0;
      #1;
   endtask : run_op

   // Model of the adder: sum, carry out of bit 7 and bit 3, zero.
   task automatic m_add(input logic [7:0] b, output logic [7:0] r);
      logic [8:0] s;
      s    = {1'b0, acc_m} + {1'b0, b};
      r    = s[7:0];
      fl_m = {s[8], ({1'b0, acc_m[3:0]} + {1'b0, b[3:0]}) > 5'h0f, r == 8'h00};
   endtask : m_add

   task automatic t_lit();
      logic [7:0] r;
      logic [7:0] ks [9] = '{8'hff, 8'h01, 8'h0f, 8'hf1, 8'h00, 8'hff, 8'hc4, 8'hf0, 8'h0f};
      foreach (ks[n]) begin
         if (n < 7) begin
            run_op({abt_pkg::CLS_LIT, abt_pkg::OPC_LIT_ADD, 1'b0, ks[n]}, 8'h00, 8'h00, 1'b0);
            m_add(ks[n], r);
            acc_m = r;
         end else begin
            run_op({abt_pkg::CLS_LIT, abt_pkg::OPC_LIT_AND, ks[n]}, 8'h00, 8'h00, 1'b0);
            acc_m   = acc_m & ks[n];
            fl_m[0] = acc_m == 8'h00;
         end
         chk_b(acc_r, acc_m, "literal acc");
         chk_s(flags_r, fl_m, "literal flags");
         chk_s({done_r, discard_r, file_wr_r.en}, 3'h4, "literal ctl");
      end
      $display("test literal ops done");
   endtask : t_lit

   task automatic t_file(input logic [3:0] opc, input logic d, input logic [6:0] a, input logic [7:0] lat,
                         input logic [7:0] pin, input logic port);
      logic [7:0] r;
      if (opc == abt_pkg::OPC_FILE_ADD) begin
         m_add(port ? pin : lat, r);
      end else begin
         r       = acc_m & (port ? pin : lat);
         fl_m[0] = r == 8'h00;
      end
      if (!d) acc_m = r;
      run_op({abt_pkg::CLS_BYTE, opc, d, a}, lat, pin, port);
      chk_b(acc_r, acc_m, "file acc");
      chk_s(flags_r, fl_m, "file flags");
      chk_s({done_r, discard_r, file_wr_r.en}, {2'b10, d}, "file ctl");
      if (d) chk_b(file_wr_r.data, r, "file data");
      if (d) chk_b({1'b0, file_wr_r.addr}, {1'b0, a}, "file addr");
      $display("test file op done");
   endtask : t_file

   task automatic t_bit(input logic [1:0] bop);
      logic [7:0] op;
      logic [7:0] m;
      for (int b = 0; b < 8; b++) begin
         op = b[0] ? 8'h5a : 8'ha5;
         m  = 8'h01 << b;
         run_op({abt_pkg::CLS_BIT, bop, 3'(b), 7'h78 + 7'(b)}, 8'ha5, 8'h5a, b[0]);
         chk_b(file_wr_r.data, (bop == abt_pkg::BOP_ONE) ? (op | m) : (op & ~m), "bit data");
         chk_b({1'b0, file_wr_r.addr}, 8'h78 + 8'(b), "bit addr");
         chk_s(flags_r, fl_m, "bit flags");
      end
      $display("test bit write done");
   endtask : t_bit

   // A test followed back to back by a literal add of one.
   task automatic t_skip(input logic [1:0] bop, input logic bv, input logic [2:0] b);
      logic       tkn;
      logic [7:0] r;
      tkn = (bop == abt_pkg::BOP_TEST_ONE) == bv;
      @(posedge mclk);
      instr_valid     <= 1'b1;
      instr           <= {abt_pkg::CLS_BIT, bop, b, 7'h20};
      file_latch_data <= bv ? (8'h01 << b) : ~(8'h01 << b);
      file_is_port    <= 1'b0;
      @(posedge mclk);
      instr <= {abt_pkg::CLS_LIT, abt_pkg::OPC_LIT_ADD, 1'b0, 8'h01};
      #1;
      chk_s({done_r, discard_r, file_wr_r.en}, {1'b1, tkn, 1'b0}, "test ctl");
      @(posedge mclk);
      instr_valid <= 1'b0;
      #1;
      if (!tkn) m_add(8'h01, r);
      if (!tkn) acc_m = r;
      chk_b(acc_r, acc_m, "follower acc");
      chk_s({done_r, discard_r, file_wr_r.en}, {!tkn, 2'b00}, "follower ctl");
      $display("test bit skip done");
   endtask : t_skip

   task automatic t_none();
      run_op({abt_pkg::CLS_BYTE, 4'h1, 8'h85}, 8'h3c, 8'h3c, 1'b0);
      chk_b(acc_r, acc_m, "ignored acc");
      chk_s(flags_r, fl_m, "ignored flags");
      chk_s({done_r, ignored_r, file_wr_r.en}, 3'h2, "ignored ctl");
      $display("test ignored op done");
   endtask : t_none

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : tally_and_finish

   // Main sequence: reset, then each scenario in turn.
   initial begin
      rstn            = 1'b0;
      instr_valid     = 1'b0;
      instr           = 14'h0000;
      file_latch_data = 8'h00;
      file_pin_data   = 8'h00;
      file_is_port    = 1'b0;
      acc_m           = 8'h00;
      fl_m            = 3'h0;
      repeat (3) @(posedge mclk);
      chk_b(acc_r, abt_pkg::ACC_RST, "reset acc");
      chk_s({done_r, discard_r, file_wr_r.en}, 3'h0, "reset ctl");
      chk_s(flags_r, abt_pkg::FLAGS_RST, "reset flags");
      rstn <= 1'b1;
      t_lit();
      t_file(abt_pkg::OPC_FILE_ADD, 1'b1, 7'h7f, 8'h5a, 8'ha5, 1'b0);
      t_file(abt_pkg::OPC_FILE_ADD, 1'b0, 7'h00, 8'h00, 8'h88, 1'b1);
      t_file(abt_pkg::OPC_FILE_ADD, 1'b0, 7'h01, 8'h77, 8'h88, 1'b1);
      t_file(abt_pkg::OPC_FILE_AND, 1'b1, 7'h15, 8'hff, 8'h30, 1'b1);
      t_file(abt_pkg::OPC_FILE_AND, 1'b0, 7'h16, 8'h01, 8'hff, 1'b0);
      t_bit(abt_pkg::BOP_ZERO);
      t_bit(abt_pkg::BOP_ONE);
      for (int n = 0; n < 4; n++) t_skip(n[1] ? abt_pkg::BOP_TEST_ONE : abt_pkg::BOP_TEST_ZERO, n[0], 3'(n + 5));
      t_none();
      tally_and_finish();
   end
endmodule : abt_exec_tb
